//--- design/hpsc_in_sync.sv
/*
  Three-stage synchroniser with agreement filter for asynchronous pin inputs.
  Assumes the input may change at any time relative to clock.
*/
module hpsc_in_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Pin and result
  input  wire logic pinIn,
  output logic      level
);

  logic stage1_r;
  logic stage2_r;
  logic stage3_r;
  logic level_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stage1_r <= RESET_VAL;
      stage2_r <= RESET_VAL;
      stage3_r <= RESET_VAL;
      level_r  <= RESET_VAL;
    end else begin
      stage1_r <= pinIn;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      if (stage2_r == stage3_r) begin
        level_r <= stage3_r;
      end
    end
  end

  assign level = level_r;

endmodule : hpsc_in_sync

//--- design/hpsc_pulse_timer.sv
/*
  One-shot timer: a start pulse holds the output high for a programmable count of cycles.
  Assumes start is a single-cycle pulse from the same clock domain.
*/
module hpsc_pulse_timer #(
  parameter logic [23:0] COUNT = 24'hbe_bc20
) (
  // Clock and reset
  input  wire logic clock,
  input  wire logic rst_n,
  // Control
  input  wire logic start,
  input  wire logic cancel,
  // Status
  output logic      busy,
  output logic      done
);

  logic [23:0] count_r;
  logic [23:0] count_nxt;
  logic        done_nxt;
  logic        busy_r;

  assign count_nxt = cancel ? 24'h00_0000 :
                     start  ? COUNT :
                     (count_r != 24'h00_0000) ? count_r - 24'h00_0001 : count_r;
  assign done_nxt  = !cancel && !start && (count_r == 24'h00_0001);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= 24'h00_0000;
      done    <= 1'b0;
      busy_r  <= 1'b0;
    end else begin
      count_r <= count_nxt;
      done    <= done_nxt;
      busy_r  <= (count_nxt != 24'h00_0000);
    end
  end

  assign busy = busy_r;

endmodule : hpsc_pulse_timer

//--- design/hpsc_slot_control.sv
/*
  Hot-plug slot control register, upper bits, with interlock pulse, slot power
  sequencing with turn-off handshake, and indicator LEDs with matching messages.
  Assumes config writes arrive as one-cycle strobes on the core clock and that
  the downstream link accepts a message when msgReady is high.
*/
// Contract
// - Bits 15:13 always read back as zero.
// - Link-state-changed flag raises interrupt only while its enable bit is one.
// - Interlock control bit reads zero; writing zero does nothing.
// - Writing one with interlock present gives one 100 ms high pulse.
// - Power control bit reports slot power, drives power pin; 0 on, 1 off.
// - Power-off with message enable sends turn-off, waits ack or 100 ms.
// - Power LED field reads, writes and drives LED; 01 on, 10 blink, 11 off.
// - Changing power LED field sends matching power indicator message.
// - Attention LED field reads, writes and drives LED; 01 means on.
// - Changing attention LED field sends matching attention indicator message.
module hpsc_slot_control #(
  parameter logic [23:0] PULSE_COUNT   = 24'(hpsc_pkg::PULSE_CYCLES),
  parameter logic [23:0] TURNOFF_COUNT = 24'(hpsc_pkg::TURNOFF_CYCLES)
) (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst_n,
  // Configuration access
  input  wire hpsc_pkg::hpsc_cfg_req_t cfgReq,
  output logic [15:0]                 cfgRdData,
  output logic                        cfgRdValid,
  // Capability and global controls
  input  wire logic                   interlockPresent,
  input  wire logic                   hotplugTurnoffMessageEnable,
  // Slot status and interrupt
  input  wire logic                   linkStateChangedFlag,
  input  wire logic                   hotplugIrqEnable,
  output logic                        linkStateIrq,
  // Low enable bits for neighbouring logic
  output logic [5:0]                  lowEnables,
  // Pins
  output logic                        interlockPulse,
  output logic                        slotPowerPin,
  output logic [1:0]                  powerLedOutput,
  output logic [1:0]                  attentionLedOutput,
  // Downstream messages
  output hpsc_pkg::hpsc_msg_t         msgOut,
  output logic                        msgValid,
  input  wire logic                   msgReady,
  input  wire logic                   turnoffAckIn
);

  // Register state
  logic       lscEnable_r;
  logic       powerCtl_r;
  logic [1:0] powerLed_r;
  logic [1:0] attentionLed_r;
  logic [5:0] lowEn_r;
  logic       lscFlagPrev_r;
  logic       ackSync;
  logic       ackPrev_r;
  hpsc_pkg::hpsc_pwr_state_t pwrState_r;
  hpsc_pkg::hpsc_pwr_state_t pwrState_nxt;

  // Pending messages
  logic turnoffPend_r;
  logic pwrIndPend_r;
  logic atnIndPend_r;

  // Timers
  logic pulseBusy;
  logic turnoffDone;
  logic turnoffBusy;

  // Access decode
  wire       hit     = (cfgReq.addr == hpsc_pkg::SLOT_CONTROL_OFFSET);
  wire       wrHi    = hit && cfgReq.wrEn && cfgReq.byteEn[1];
  wire       wrLo    = hit && cfgReq.wrEn && cfgReq.byteEn[0];
  wire [15:0] wd     = cfgReq.wrData;
  wire       newPwr  = wd[hpsc_pkg::POWER_CTL_POS];
  wire [1:0] newPLed = wd[hpsc_pkg::POWER_LED_OUTPUT_LO_POS +: 2];
  wire [1:0] newALed = wd[hpsc_pkg::ATTENTION_LED_OUTPUT_LO_POS +: 2];
  wire       pulseGo = wrHi && wd[hpsc_pkg::INTERLOCK_POS] && interlockPresent;
  wire       goOff   = wrHi && (powerCtl_r == hpsc_pkg::POWER_ON)
                       && (newPwr == hpsc_pkg::POWER_OFF);
  wire       goOn    = wrHi && (newPwr == hpsc_pkg::POWER_ON);
  wire       pLedChg = wrHi && (newPLed != powerLed_r);
  wire       aLedChg = wrLo && (newALed != attentionLed_r);
  wire       ackRise = ackSync && !ackPrev_r;

  // Read value: reserved and interlock bits read zero
  wire [15:0] rdValue = {3'h0, lscEnable_r, 1'b0, powerCtl_r,
                         powerLed_r, attentionLed_r, lowEn_r};

  // Power sequencer next state
  always_comb begin
    pwrState_nxt = pwrState_r;
    case (pwrState_r)
      hpsc_pkg::HPSC_SLOT_POWER_OUTPUT: begin
        if (goOff) begin
          pwrState_nxt = hotplugTurnoffMessageEnable ? hpsc_pkg::HPSC_PWR_WAITACK
                                                     : hpsc_pkg::HPSC_PWR_OFF;
        end
      end
      hpsc_pkg::HPSC_PWR_WAITACK: begin
        if (goOn) begin
          pwrState_nxt = hpsc_pkg::HPSC_SLOT_POWER_OUTPUT;
        end else if (ackRise || turnoffDone) begin
          pwrState_nxt = hpsc_pkg::HPSC_PWR_OFF;
        end
      end
      hpsc_pkg::HPSC_PWR_OFF: begin
        if (goOn) begin
          pwrState_nxt = hpsc_pkg::HPSC_SLOT_POWER_OUTPUT;
        end
      end
      default: pwrState_nxt = hpsc_pkg::HPSC_PWR_OFF;
    endcase
  end

  // Message arbitration: turn-off first, then power, then attention
  wire sendTo  = turnoffPend_r;
  wire sendPwr = !turnoffPend_r && pwrIndPend_r;
  wire sendAtn = !turnoffPend_r && !pwrIndPend_r && atnIndPend_r;
  assign msgValid = turnoffPend_r || pwrIndPend_r || atnIndPend_r;
  wire   msgTake  = msgValid && msgReady;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lscEnable_r    <= hpsc_pkg::SLOT_CONTROL_RESET[hpsc_pkg::LSC_EN_POS];
      powerCtl_r     <= hpsc_pkg::SLOT_CONTROL_RESET[hpsc_pkg::POWER_CTL_POS];
      powerLed_r     <= hpsc_pkg::SLOT_CONTROL_RESET[hpsc_pkg::POWER_LED_OUTPUT_LO_POS +: 2];
      attentionLed_r <= hpsc_pkg::SLOT_CONTROL_RESET[hpsc_pkg::ATTENTION_LED_OUTPUT_LO_POS +: 2];
      lowEn_r        <= hpsc_pkg::SLOT_CONTROL_RESET[5:0];
      pwrState_r     <= hpsc_pkg::HPSC_PWR_OFF;
    end else begin
      if (wrHi) begin
        lscEnable_r <= wd[hpsc_pkg::LSC_EN_POS];
        powerCtl_r  <= newPwr;
        powerLed_r  <= newPLed;
      end
      if (wrLo) begin
        attentionLed_r <= newALed;
        lowEn_r        <= wd[5:0];
      end
      pwrState_r <= pwrState_nxt;
    end
  end

  // Pending flags: a new request wins over the clear from a take
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      turnoffPend_r <= 1'b0;
      pwrIndPend_r  <= 1'b0;
      atnIndPend_r  <= 1'b0;
      msgOut        <= '0;
    end else begin
      turnoffPend_r <= (goOff && hotplugTurnoffMessageEnable) || (turnoffPend_r && !(msgTake && sendTo));
      pwrIndPend_r  <= pLedChg || (pwrIndPend_r && !(msgTake && sendPwr));
      atnIndPend_r  <= aLedChg || (atnIndPend_r && !(msgTake && sendAtn));
      if (!msgValid || msgTake) begin
        msgOut.kind  <= hpsc_pkg::HPSC_MSG_NONE;
        msgOut.state <= 2'h0;
      end
      if (sendTo) begin
        msgOut.kind  <= hpsc_pkg::HPSC_MSG_TURN_OFF;
        msgOut.state <= 2'h0;
      end else if (sendPwr) begin
        msgOut.kind  <= hpsc_pkg::HPSC_MSG_PWR_IND;
        msgOut.state <= powerLed_r;
      end else if (sendAtn) begin
        msgOut.kind  <= hpsc_pkg::HPSC_MSG_ATN_IND;
        msgOut.state <= attentionLed_r;
      end
    end
  end

  // Interrupt, read port and pins
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      lscFlagPrev_r  <= 1'b0;
      linkStateIrq   <= 1'b0;
      ackPrev_r      <= 1'b0;
      cfgRdData      <= 16'h0000;
      cfgRdValid     <= 1'b0;
      slotPowerPin   <= 1'b0;
    end else begin
      lscFlagPrev_r <= linkStateChangedFlag;
      linkStateIrq  <= linkStateChangedFlag && !lscFlagPrev_r
                       && lscEnable_r && hotplugIrqEnable;
      ackPrev_r     <= ackSync;
      cfgRdValid    <= hit && cfgReq.rdEn;
      cfgRdData     <= (hit && cfgReq.rdEn) ? rdValue : 16'h0000;
      slotPowerPin  <= (pwrState_nxt != hpsc_pkg::HPSC_PWR_OFF);
    end
  end

  assign lowEnables         = lowEn_r;
  assign interlockPulse     = pulseBusy;
  assign powerLedOutput     = powerLed_r;
  assign attentionLedOutput = attentionLed_r;

  hpsc_in_sync #(
    .RESET_VAL (1'b0)
  ) u_ack_sync (
    .clock (clock),
    .rst_n (rst_n),
    .pinIn (turnoffAckIn),
    .level (ackSync)
  );

  hpsc_pulse_timer #(
    .COUNT (PULSE_COUNT)
  ) u_interlock_timer (
    .clock  (clock),
    .rst_n  (rst_n),
    .start  (pulseGo && !pulseBusy),
    .cancel (1'b0),
    .busy   (pulseBusy),
    .done   ()
  );

  hpsc_pulse_timer #(
    .COUNT (TURNOFF_COUNT)
  ) u_turnoff_timer (
    .clock  (clock),
    .rst_n  (rst_n),
    .start  (goOff && hotplugTurnoffMessageEnable),
    .cancel (pwrState_r != hpsc_pkg::HPSC_PWR_WAITACK && !goOff),
    .busy   (turnoffBusy),
    .done   (turnoffDone)
  );

  // Checks
  chk_reserved_read_zero: assert property (@(posedge clock) disable iff (!rst_n)
    cfgRdValid |-> cfgRdData[15:13] == 3'h0) else $error("reserved bits not zero");
  chk_interlock_reads_zero: assert property (@(posedge clock) disable iff (!rst_n)
    cfgRdValid |-> !cfgRdData[11]) else $error("interlock bit read as one");
  chk_irq_needs_enable: assert property (@(posedge clock) disable iff (!rst_n)
    linkStateIrq |-> $past(lscEnable_r) && $past(linkStateChangedFlag))
    else $error("irq without enable");
  chk_pulse_starts_high: assert property (@(posedge clock) disable iff (!rst_n)
    (pulseGo && !pulseBusy) |=> interlockPulse[*8]) else $error("pulse too short");
  chk_no_pulse_absent: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(interlockPulse) |-> $past(interlockPresent)) else $error("pulse without interlock");
  chk_direct_power_off: assert property (@(posedge clock) disable iff (!rst_n)
    (goOff && !hotplugTurnoffMessageEnable) |=> !slotPowerPin && !turnoffPend_r)
    else $error("direct power off failed");
  chk_turnoff_holds_power: assert property (@(posedge clock) disable iff (!rst_n)
    (goOff && hotplugTurnoffMessageEnable) |=> slotPowerPin && turnoffPend_r)
    else $error("power dropped before ack");
  chk_led_follows_write: assert property (@(posedge clock) disable iff (!rst_n)
    wrHi |=> powerLedOutput == $past(newPLed)) else $error("power led not updated");
  chk_atn_msg_queued: assert property (@(posedge clock) disable iff (!rst_n)
    aLedChg |=> atnIndPend_r) else $error("attention message lost");
  chk_pwr_msg_queued: assert property (@(posedge clock) disable iff (!rst_n)
    pLedChg |=> pwrIndPend_r ##0 powerLedOutput != $past(powerLedOutput))
    else $error("power message lost");

  // Pin is a registered copy of the sequencer's on/off view
  chk_pin_matches_state: assert property (@(posedge clock) disable iff (!rst_n)
    slotPowerPin == (pwrState_r != hpsc_pkg::HPSC_PWR_OFF))
    else $error("power pin disagrees with sequencer");

  // Acknowledge while waiting drops power at the next edge
  chk_ack_drops_power: assert property (@(posedge clock) disable iff (!rst_n)
    (pwrState_r == hpsc_pkg::HPSC_PWR_WAITACK && ackRise && !goOn) |=> !slotPowerPin)
    else $error("power kept after acknowledge");

  // Turn-off timer is stopped once power is off
  chk_turnoff_timer_idle: assert property (@(posedge clock) disable iff (!rst_n)
    (pwrState_r == hpsc_pkg::HPSC_PWR_OFF) |=> !turnoffBusy)
    else $error("turn-off timer running with power off");

  // Attention field follows a low-byte write
  chk_atn_follows_write: assert property (@(posedge clock) disable iff (!rst_n)
    wrLo |=> attentionLedOutput == $past(newALed))
    else $error("attention led not updated");

  // A message offered and not taken stays offered
  chk_msg_held: assert property (@(posedge clock) disable iff (!rst_n)
    (msgValid && !msgReady) |=> msgValid)
    else $error("message withdrawn before take");

  // Interrupt is a single-cycle pulse per flag edge
  chk_irq_one_cycle: assert property (@(posedge clock) disable iff (!rst_n)
    linkStateIrq |=> !linkStateIrq)
    else $error("interrupt longer than one cycle");

  // Unmapped reads give no read strobe
  chk_unmapped_silent: assert property (@(posedge clock) disable iff (!rst_n)
    (cfgReq.rdEn && !hit) |=> !cfgRdValid)
    else $error("read strobe on unmapped address");

  // Interlock pulse never starts while the capability is absent
  chk_no_start_absent: assert property (@(posedge clock) disable iff (!rst_n)
    (!interlockPresent && !interlockPulse) |=> !interlockPulse)
    else $error("pulse started without interlock");

endmodule : hpsc_slot_control

//--- dv/hpsc_link_model.sv
/*
  Downstream link and device model: takes indicator and turn-off messages,
  can stall, and answers a turn-off with an acknowledge pulse.
  Assumes msgOut is settled the cycle after msgValid rises.
*/
module hpsc_link_model #(
  parameter int ACK_DELAY = 5
) (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                rst_n,
  // Message link
  input  wire hpsc_pkg::hpsc_msg_t msgOut,
  input  wire logic                msgValid,
  output logic                     msgReady,
  output logic                     turnoffAckIn,
  // Behaviour controls
  input  wire logic                stallOn,
  input  wire logic                ackOn
);
  timeunit 1ns;
  timeprecision 1ps;

  hpsc_pkg::hpsc_msg_t got[$];
  int                  ackCnt;
  integer              seed = 32'hb5cb;
  wire logic           take = msgReady && msgValid;

  // Ready drops for a cycle after each take so a stale msgOut is never taken
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      msgReady <= 1'b0;
      turnoffAckIn <= 1'b0;
      ackCnt <= 0;
    end else begin
      msgReady <= msgValid && (msgOut.kind != hpsc_pkg::HPSC_MSG_NONE) && !take
                  && (!stallOn || (($random(seed) & 1) == 0));
      if (take) got.push_back(msgOut);
      if (take && msgOut.kind == hpsc_pkg::HPSC_MSG_TURN_OFF && ackOn) ackCnt <= ACK_DELAY + 6;
      else if (ackCnt > 0) ackCnt <= ackCnt - 1;
      // Acknowledge held six cycles so the pin filter sees it
      turnoffAckIn <= (ackCnt > 0) && (ackCnt <= 6);
    end
  end
endmodule : hpsc_link_model

//--- dv/tb_hotplug_slot_control.sv
/*
  Self-checking bench for the slot control register: read-back, indicators and
  messages, interlock pulse, link-state interrupt and power sequencing.
  Assumes shortened pulse and turn-off counts of 20 cycles.
*/
module tb_hotplug_slot_control;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [23:0] CNT = 24'h00_0014;
  localparam logic [11:0] OFS = hpsc_pkg::SLOT_CONTROL_OFFSET;

  logic                    clock = 1'b0;
  logic                    rst_n = 1'b0;
  hpsc_pkg::hpsc_cfg_req_t cfgReq = '0;
  logic                    interlockPresent = 1'b0;
  logic                    turnoffEn = 1'b0;
  logic                    lscFlag = 1'b0;
  logic                    irqEn = 1'b0;
  logic                    stallOn = 1'b0;
  logic                    ackOn = 1'b0;
  logic [15:0]             cfgRdData;
  logic                    cfgRdValid, linkStateIrq, interlockPulse, slotPowerPin;
  logic                    msgValid, msgReady, turnoffAckIn;
  logic [5:0]              lowEnables;
  logic [1:0]              powerLedOutput, attentionLedOutput;
  hpsc_pkg::hpsc_msg_t     msgOut;
  hpsc_pkg::hpsc_msg_t     expQ[$];
  logic [15:0]             shadow = hpsc_pkg::SLOT_CONTROL_RESET;
  int                      numErrors = 0;
  int                      samplesChecked = 0;
  integer                  seed = 32'hb5cb;

  hpsc_slot_control #(.PULSE_COUNT(CNT), .TURNOFF_COUNT(CNT)) i_dut (
    .clock(clock), .rst_n(rst_n), .cfgReq(cfgReq), .cfgRdData(cfgRdData),
    .cfgRdValid(cfgRdValid), .interlockPresent(interlockPresent),
    .hotplugTurnoffMessageEnable(turnoffEn), .linkStateChangedFlag(lscFlag),
    .hotplugIrqEnable(irqEn), .linkStateIrq(linkStateIrq), .lowEnables(lowEnables),
    .interlockPulse(interlockPulse), .slotPowerPin(slotPowerPin),
    .powerLedOutput(powerLedOutput), .attentionLedOutput(attentionLedOutput),
    .msgOut(msgOut), .msgValid(msgValid), .msgReady(msgReady), .turnoffAckIn(turnoffAckIn)
  );

  hpsc_link_model i_link (
    .clock(clock), .rst_n(rst_n), .msgOut(msgOut), .msgValid(msgValid),
    .msgReady(msgReady), .turnoffAckIn(turnoffAckIn), .stallOn(stallOn), .ackOn(ackOn)
  );

  initial begin
    forever #4 clock = ~clock;
  end

  task automatic summarize();
    $display("checks %0d errors %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    samplesChecked++;
    if (got !== exp) begin
      $display("wrong value %s expected %h seen %h", nm, exp, got);
      numErrors++;
    end
  endtask : chk

  // Reserved and interlock bits always read zero
  function automatic logic [15:0] merge(input logic [15:0] o, d, input logic [1:0] be);
    return {be[1] ? d[15:8] : o[15:8], be[0] ? d[7:0] : o[7:0]} & 16'h17ff;
  endfunction : merge

  task automatic wr(input logic [15:0] d, input logic [1:0] be, input logic [11:0] a);
    logic [15:0] n;
    n = merge(shadow, d, be);
    @(posedge clock);
    cfgReq <= {1'b1, 1'b0, a, d, be};
    @(posedge clock);
    cfgReq <= '0;
    if (a == OFS) begin
      if (n[9:8] != shadow[9:8]) expQ.push_back({hpsc_pkg::HPSC_MSG_PWR_IND, n[9:8]});
      if (n[7:6] != shadow[7:6]) expQ.push_back({hpsc_pkg::HPSC_MSG_ATN_IND, n[7:6]});
      shadow = n;
    end
  endtask : wr

  task automatic rd(input logic [11:0] a);
    @(posedge clock);
    cfgReq <= {1'b0, 1'b1, a, 16'h0000, 2'b11};
    @(posedge clock);
    cfgReq <= '0;
    #1;
    chk("rdValid", {15'h0000, a == OFS}, {15'h0000, cfgRdValid});
    if (a == OFS) chk("slotControl", shadow, cfgRdData);
  endtask : rd

  task automatic chkMsgs();
    repeat (40) @(posedge clock);
    chk("msgCount", 16'(expQ.size()), 16'(i_link.got.size()));
    foreach (expQ[k]) begin
      if (k < i_link.got.size()) begin
        chk("msgKind", 16'(expQ[k].kind), 16'(i_link.got[k].kind));
        if (expQ[k].kind != hpsc_pkg::HPSC_MSG_TURN_OFF)
          chk("msgState", 16'(expQ[k].state), 16'(i_link.got[k].state));
      end
    end
    expQ.delete();
    i_link.got.delete();
  endtask : chkMsgs

  task automatic countHigh(ref logic sig, input int span, output int n);
    n = 0;
    repeat (span) begin
      @(posedge clock);
      if (sig === 1'b1) n++;
    end
  endtask : countHigh

  initial begin
    #80000;
    numErrors++;
    summarize();
  end

  initial begin
    int n;
    logic [15:0] d;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(OFS);
    chk("powerPin", 16'h0000, {15'h0000, slotPowerPin});
    // Every non-reserved indicator code first, then random writes with random byte enables
    for (int k = 0; k < 24; k++) begin
      d = $random(seed);
      if (k < 3) d[9:6] = {2'(k + 1), 2'(3 - k)};
      d[10] = shadow[10];
      d[8] = d[8] | ~d[9];
      d[6] = d[6] | ~d[7];
      stallOn <= k[0];
      wr(d, (k < 3) ? 2'b11 : 2'($random(seed)), OFS);
      rd(OFS);
      chk("powerLed", {14'h0000, shadow[9:8]}, {14'h0000, powerLedOutput});
      chk("attnLed", {14'h0000, shadow[7:6]}, {14'h0000, attentionLedOutput});
      chk("lowEnables", {10'h000, shadow[5:0]}, {10'h000, lowEnables});
      chkMsgs();
    end
    wr(16'hffff, 2'b11, OFS + 12'h004);
    rd(OFS + 12'h004);
    rd(OFS);
    stallOn <= 1'b0;
    for (int p = 0; p < 2; p++) begin
      interlockPresent <= p[0];
      wr(shadow | 16'h0800, 2'b10, OFS);
      countHigh(interlockPulse, 40, n);
      chk("pulseCycles", p ? 16'(CNT) : 16'h0000, 16'(n));
    end
    irqEn <= 1'b1;
    for (int e = 0; e < 2; e++) begin
      wr({shadow[15:13], e[0], shadow[11:0]}, 2'b10, OFS);
      lscFlag <= 1'b1;
      countHigh(linkStateIrq, 10, n);
      lscFlag <= 1'b0;
      chk("irqPulses", 16'(e), 16'(n));
    end
    for (int m = 0; m < 3; m++) begin
      turnoffEn <= (m != 0);
      ackOn <= (m == 1);
      wr(shadow & 16'hfbff, 2'b10, OFS);
      repeat (3) @(posedge clock);
      chk("powerPinOn", 16'h0001, {15'h0000, slotPowerPin});
      if (m != 0) expQ.push_back({hpsc_pkg::HPSC_MSG_TURN_OFF, 2'b00});
      wr(shadow | 16'h0400, 2'b10, OFS);
      n = 0;
      while (slotPowerPin === 1'b1 && n < 200) begin
        @(posedge clock);
        n++;
      end
      if (m == 0) chk("offDirect", 16'h0001, 16'(n <= 2));
      if (m == 1) chk("offByAck", 16'h0001, 16'(n >= 5 && n < CNT));
      if (m == 2) chk("offByTimeout", 16'h0001, 16'(n >= CNT - 2 && n <= CNT + 10));
      rd(OFS);
      chkMsgs();
    end
    summarize();
  end
endmodule : tb_hotplug_slot_control

//--- inc/hpsc_pkg.sv
/*
  Package for the hot-plug slot control block: register offset, field positions,
  reset value, indicator codes, message codes, timing constants and carrier structs.
  Assumes a 125 MHz core clock.
*/
package hpsc_pkg;

  // Register location and reset
  localparam logic [11:0] SLOT_CONTROL_OFFSET = 12'h0a8;
  localparam logic [15:0] SLOT_CONTROL_RESET  = 16'h07c0;

  // Field positions
  localparam int RSVD_HI_POS    = 13;
  localparam int LSC_EN_POS     = 12;
  localparam int INTERLOCK_POS  = 11;
  localparam int POWER_CTL_POS  = 10;
  localparam int POWER_LED_OUTPUT_LO_POS = 8;
  localparam int ATTENTION_LED_OUTPUT_LO_POS = 6;
  localparam int LOW_EN_WIDTH   = 6;

  // Indicator codes
  localparam logic [1:0] LED_RESERVED = 2'h0;
  localparam logic [1:0] LED_ON       = 2'h1;
  localparam logic [1:0] LED_BLINK    = 2'h2;
  localparam logic [1:0] LED_OFF      = 2'h3;

  // Power control codes
  localparam logic POWER_ON  = 1'b0;
  localparam logic POWER_OFF = 1'b1;

  // Timing
  localparam int CLOCK_MHZ        = 125;
  localparam int PULSE_TIME_MS    = 100;
  localparam int TURNOFF_TIME_MS  = 100;
  localparam int PULSE_CYCLES     = PULSE_TIME_MS * 1000 * CLOCK_MHZ;
  localparam int TURNOFF_CYCLES   = TURNOFF_TIME_MS * 1000 * CLOCK_MHZ;
  localparam int TIMER_WIDTH      = 24;

  // Downstream message kinds
  typedef enum logic [2:0] {
    HPSC_MSG_NONE      = 3'b000,
    HPSC_MSG_TURN_OFF  = 3'b001,
    HPSC_MSG_PWR_IND   = 3'b010,
    HPSC_MSG_ATN_IND   = 3'b011
  } hpsc_msg_kind_t;

  // Message request toward the downstream link
  typedef struct packed {
    hpsc_msg_kind_t kind;
    logic [1:0]     state;
  } hpsc_msg_t;

  // Configuration write/read port
  typedef struct packed {
    logic        wrEn;
    logic        rdEn;
    logic [11:0] addr;
    logic [15:0] wrData;
    logic [1:0]  byteEn;
  } hpsc_cfg_req_t;

  // Power sequencer states
  typedef enum logic [1:0] {
    HPSC_SLOT_POWER_OUTPUT      = 2'b00,
    HPSC_PWR_WAITACK = 2'b01,
    HPSC_PWR_OFF     = 2'b10
  } hpsc_pwr_state_t;

endpackage : hpsc_pkg
